// File: verilog/rx_path_pointer_defect_monitor.sv
// Purpose: declare and clear pointer loss, path alarm and remote defect instability
// Assumes: frame inputs come from a framer on the same clock
// Notes:   all defect logic steps only on the frame boundary strobe
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ptr_defect_defs.svh"

module rx_path_pointer_defect_monitor (
  input  wire logic                        SYS_CLK,
  input  wire logic                        SYS_RST,
  input  wire logic                        CLK_EN,
  input  wire ptr_defect_pkg::frame_info_t FRAME,
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [5:0]                  WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [31:0]                 WB_DAT_I,
  output logic [31:0]                      WB_DAT_O,
  output logic                             WB_ACK_O,
  output logic                             PATH_POINTER_LOSS,
  output logic                             PATH_ALARM_INDICATION,
  output logic                             REMOTE_DEFECT_UNSTABLE,
  output logic                             IRQ
);

  ptr_defect_pkg::mon_state_t s_r;
  ptr_defect_pkg::mon_state_t s_nxt;

  logic       ones;
  logic       good;
  logic       lop_dec;
  logic       ais_dec;
  logic       lop_now;
  logic       ais_now;
  logic [2:0] status;
  logic [2:0] status_nxt;
  logic       req;
  logic       wr;

  ////////////////////////////////////////////////////////////////////////////
  // frame classification

  assign ones = (FRAME.h1 == `PTR_ONES) && (FRAME.h2 == `PTR_ONES)
             && (FRAME.h3 == `PTR_ONES);
  // valid pointer with a normal flag; used by the loss clear path only
  assign good = FRAME.ptr_valid && !FRAME.new_data_flag && !ones;

  assign lop_now = (s_r.st == ptr_defect_pkg::ST_LOP);
  assign ais_now = (s_r.st == ptr_defect_pkg::ST_AIS);
  assign status  = {s_r.rdi_unst, lop_now, ais_now};

  assign req = WB_CYC_I && WB_STB_I && !s_r.ack;
  assign wr  = req && WB_WE_I && WB_SEL_I[0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt      = s_r;
    lop_dec    = 1'b0;
    ais_dec    = 1'b0;
    status_nxt = status;

    if (FRAME.frame_end) begin
      // all-ones pointer frames with an all-ones envelope count toward the alarm; all-ones pointers never count toward loss
      s_nxt.ais_cnt = (ones && FRAME.spe_all_ones)
                    ? ((s_r.ais_cnt == `AIS_WIN_CNT) ? s_r.ais_cnt : s_r.ais_cnt + 2'h1)
                    : 2'h0;
      s_nxt.inv_cnt = (!FRAME.ptr_valid && !ones)
                    ? ((s_r.inv_cnt == `LOP_DECLARE_CNT) ? s_r.inv_cnt : s_r.inv_cnt + 4'h1)
                    : 4'h0;
      s_nxt.ndf_cnt = (FRAME.ptr_valid && FRAME.new_data_flag && !ones)
                    ? ((s_r.ndf_cnt == `LOP_DECLARE_CNT) ? s_r.ndf_cnt : s_r.ndf_cnt + 4'h1)
                    : 4'h0;
      s_nxt.good_cnt = (FRAME.ptr_valid && !ones)
                     ? ((s_r.good_cnt == `CLEAR_CNT) ? s_r.good_cnt : s_r.good_cnt + 2'h1)
                     : 2'h0;

      ais_dec = (s_nxt.ais_cnt == `AIS_WIN_CNT);
      lop_dec = (s_nxt.inv_cnt == `LOP_DECLARE_CNT)
             || (s_nxt.ndf_cnt == `LOP_DECLARE_CNT);

      unique case (s_r.st)
        ptr_defect_pkg::ST_NORM: begin
          if (ais_dec) begin
            s_nxt.st = ptr_defect_pkg::ST_AIS;
          end else if (lop_dec) begin
            s_nxt.st = ptr_defect_pkg::ST_LOP;
          end
        end
        ptr_defect_pkg::ST_LOP: begin
          if (ais_dec) begin
            s_nxt.st = ptr_defect_pkg::ST_AIS;
          end else if (good) begin
            s_nxt.good_cnt = (s_r.good_cnt == `CLEAR_CNT) ? s_r.good_cnt
                           : s_r.good_cnt + 2'h1;
            if (s_nxt.good_cnt == `CLEAR_CNT) begin
              s_nxt.st = ptr_defect_pkg::ST_NORM;
            end
          end else begin
            s_nxt.good_cnt = 2'h0;
          end
        end
        ptr_defect_pkg::ST_AIS: begin
          // set or normal flag both count here
          if (s_nxt.good_cnt == `CLEAR_CNT) begin
            s_nxt.st = ptr_defect_pkg::ST_NORM;
          end
        end
        default: s_nxt.st = ptr_defect_pkg::ST_NORM;
      endcase
      if (s_r.st != s_nxt.st) begin
        s_nxt.good_cnt = 2'h0;
      end

      // remote defect instability, one step per frame
      if (FRAME.path_remote_defect_indicator != s_r.rdi_prev) begin
        s_nxt.rdi_same_cnt = 4'h0;
        s_nxt.rdi_unst_cnt = (s_r.rdi_unst_cnt == 4'hf) ? s_r.rdi_unst_cnt
                           : s_r.rdi_unst_cnt + 4'h1;
      end else begin
        s_nxt.rdi_same_cnt = (s_r.rdi_same_cnt == 4'hf) ? s_r.rdi_same_cnt
                           : s_r.rdi_same_cnt + 4'h1;
        if (s_nxt.rdi_same_cnt >= s_r.thrd) begin
          s_nxt.rdi_unst_cnt = 4'h0;
        end
      end
      s_nxt.rdi_prev = FRAME.path_remote_defect_indicator;
      // a zero threshold would declare on every frame; treat it as never
      s_nxt.rdi_unst = (s_r.thrd != 4'h0) && (s_nxt.rdi_unst_cnt >= s_r.thrd);

      status_nxt = {s_nxt.rdi_unst,
                    s_nxt.st == ptr_defect_pkg::ST_LOP,
                    s_nxt.st == ptr_defect_pkg::ST_AIS};
    end

    // register bus: ack registered one cycle after the request, ack for one cycle
    s_nxt.ack     = req;
    s_nxt.rd_data = 8'h00;
    if (req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        `OFS_STATUS:   s_nxt.rd_data = {5'h00, status};
        `OFS_RDI_CFG:  s_nxt.rd_data = {4'h0, s_r.thrd};
        `OFS_IRQ_STAT: s_nxt.rd_data = {5'h00, s_r.irq_stat};
        `OFS_IRQ_MASK: s_nxt.rd_data = {5'h00, s_r.irq_mask};
        default:       s_nxt.rd_data = 8'h00;
      endcase
    end
    if (wr && (WB_ADR_I == `OFS_RDI_CFG)) begin
      s_nxt.thrd = WB_DAT_I[3:0];
    end
    if (wr && (WB_ADR_I == `OFS_IRQ_MASK)) begin
      s_nxt.irq_mask = WB_DAT_I[2:0];
    end

    // any change of a defect is an event; a new event wins over the clear
    s_nxt.irq_stat = s_r.irq_stat;
    if (wr && (WB_ADR_I == `OFS_IRQ_STAT)) begin
      s_nxt.irq_stat = s_r.irq_stat & ~WB_DAT_I[2:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | (status_nxt ^ status);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      s_r              <= '0;
      s_r.st           <= ptr_defect_pkg::ST_NORM;
      s_r.thrd         <= `THRD_RESET;
    end else if (CLK_EN) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign WB_DAT_O               = {24'h000000, s_r.rd_data};
  assign WB_ACK_O               = s_r.ack;
  assign PATH_POINTER_LOSS      = lop_now;
  assign PATH_ALARM_INDICATION  = ais_now;
  assign REMOTE_DEFECT_UNSTABLE = s_r.rdi_unst;
  assign IRQ                    = |(s_r.irq_stat & s_r.irq_mask);

endmodule : rx_path_pointer_defect_monitor
`default_nettype wire

// File: verilog/ptr_defect_defs.svh
// Purpose: constants for the receive path pointer defect monitor
// Assumes: 50 MHz system clock, classic wishbone with 8-bit register words
// Notes:   offsets are byte addresses of aligned 32-bit words
`ifndef PTR_DEFECT_DEFS_SVH
`define PTR_DEFECT_DEFS_SVH

`define OFS_STATUS      6'h00
`define OFS_RDI_CFG     6'h04
`define OFS_IRQ_STAT    6'h08
`define OFS_IRQ_MASK    6'h0c

`define BIT_AIS         0
`define BIT_LOP         1
`define BIT_RDI_UNST    2

`define LOP_DECLARE_CNT 4'h8
`define CLEAR_CNT       2'h3
`define AIS_WIN_CNT     2'h3
`define THRD_RESET      4'hf
`define PTR_ONES        8'hff

`endif

// File: verilog/ptr_defect_pkg.sv
// Purpose: types for the receive path pointer defect monitor
// Assumes: one tributary, one frame strobe per received frame
// Notes:   frame summary is presented with the frame boundary strobe
package ptr_defect_pkg;

  typedef enum logic [2:0] {
    ST_NORM = 3'b001,
    ST_LOP  = 3'b010,
    ST_AIS  = 3'b100
  } ptr_state_t;

  typedef struct packed {
    logic       frame_end;
    logic [7:0] h1;
    logic [7:0] h2;
    logic [7:0] h3;
    logic       ptr_valid;
    logic       new_data_flag;
    logic       spe_all_ones;
    logic       path_remote_defect_indicator;
  } frame_info_t;

  typedef struct packed {
    ptr_state_t  st;
    logic [3:0]  inv_cnt;
    logic [3:0]  ndf_cnt;
    logic [1:0]  good_cnt;
    logic [1:0]  ais_cnt;
    logic        rdi_prev;
    logic [3:0]  rdi_same_cnt;
    logic [3:0]  rdi_unst_cnt;
    logic        rdi_unst;
    logic [3:0]  thrd;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [7:0]  rd_data;
    logic        ack;
  } mon_state_t;

endpackage : ptr_defect_pkg

// File: dv/rx_frame_src.sv
// Purpose: line-side frame source for the pointer defect monitor
// Assumes: shares the monitor clock
// Notes: fields toggle off the boundary so a stale frame never looks valid
`timescale 1ns/1ps
`default_nettype none
module rx_frame_src (
  input  wire logic                   clk,
  output ptr_defect_pkg::frame_info_t frame
);
  initial frame = '0;
  // n frames of one kind; all-ones pointer bytes also mean all-ones envelope
  task automatic send(input int n, input logic [7:0] h, input logic v, f, r);
    repeat (n) begin
      @(posedge clk);
      frame <= {1'b1, h, h, h, v, f, &h, r};
      @(posedge clk);
      frame <= {1'b0, ~h, ~h, ~h, ~v, ~f, ~&h, ~r};
    end
  endtask : send
endmodule : rx_frame_src
`default_nettype wire

// File: dv/rx_path_pointer_defect_monitor_properties.sv
// Purpose: port-level checks of the pointer defect monitor
// Assumes: one clock, synchronous reset
// Notes: defect edges are tied to the frame that caused them
`timescale 1ns/1ps
`default_nettype none
module rx_path_pointer_defect_monitor_properties (
  input wire logic                        SYS_CLK,
  input wire logic                        SYS_RST,
  input wire logic                        CLK_EN,
  input wire ptr_defect_pkg::frame_info_t FRAME,
  input wire logic                        WB_CYC_I,
  input wire logic                        WB_STB_I,
  input wire logic [31:0]                 WB_DAT_O,
  input wire logic                        WB_ACK_O,
  input wire logic                        PATH_POINTER_LOSS,
  input wire logic                        PATH_ALARM_INDICATION,
  input wire logic                        REMOTE_DEFECT_UNSTABLE
);
  logic fe;
  logic aisp;
  assign fe   = CLK_EN & FRAME.frame_end;
  assign aisp = &{FRAME.h1, FRAME.h2, FRAME.h3, FRAME.spe_all_ones};
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_ack_take; CLK_EN && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not answered");
  property p_ack_drop; WB_ACK_O && CLK_EN |=> !WB_ACK_O ##0 WB_DAT_O[31:8] == 24'h0; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
  property p_frame_only;
    !$stable({PATH_POINTER_LOSS, PATH_ALARM_INDICATION, REMOTE_DEFECT_UNSTABLE}) |-> $past(fe);
  endproperty
  a_frame_only: assert property (p_frame_only) else $error("defect moved off boundary");
  property p_lop_rise; $rose(PATH_POINTER_LOSS) |-> $past(fe && !aisp); endproperty
  a_lop_rise: assert property (p_lop_rise) else $error("loss raised by alarm frame");
  property p_lop_cause;
    $rose(PATH_POINTER_LOSS) |-> $past(!FRAME.ptr_valid || FRAME.new_data_flag);
  endproperty
  a_lop_cause: assert property (p_lop_cause) else $error("loss raised by good frame");
  property p_lop_fall;
    $fell(PATH_POINTER_LOSS) |-> PATH_ALARM_INDICATION
      || $past(FRAME.ptr_valid && !FRAME.new_data_flag);
  endproperty
  a_lop_fall: assert property (p_lop_fall) else $error("loss cleared by bad frame");
  property p_ais_rise; $rose(PATH_ALARM_INDICATION) |-> $past(aisp); endproperty
  a_ais_rise: assert property (p_ais_rise) else $error("alarm without all ones");
  property p_ais_fall; $fell(PATH_ALARM_INDICATION) |-> $past(FRAME.ptr_valid); endproperty
  a_ais_fall: assert property (p_ais_fall) else $error("alarm cleared by bad frame");
endmodule : rx_path_pointer_defect_monitor_properties
bind rx_path_pointer_defect_monitor rx_path_pointer_defect_monitor_properties props (.*);
`default_nettype wire

// File: dv/rx_path_pointer_defect_monitor_tb.sv
// Purpose: self-checking bench of the pointer defect monitor
// Assumes: classic wishbone, one frame source
// Notes: CLK_EN held high except in t_freeze, which offers frames while it is low
`timescale 1ns/1ps
`default_nettype none
module rx_path_pointer_defect_monitor_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        ack, lop, ais, unst, irq;
  int          miscompares = 0, comparisons = 0;
  ptr_defect_pkg::frame_info_t frame;
  always #10 clk = ~clk;
  rx_frame_src src (.clk(clk), .frame(frame));
  rx_path_pointer_defect_monitor dut (.SYS_CLK(clk), .SYS_RST(rst), .CLK_EN(en),
    .FRAME(frame), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PATH_POINTER_LOSS(lop), .PATH_ALARM_INDICATION(ais),
    .REMOTE_DEFECT_UNSTABLE(unst), .IRQ(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    #1;
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    // the wait ends when ack is seen; only the watchdog ends it if ack never comes
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    chk(ack, 1'b1);
  endtask : bus
  // status read through the register, then at the pins once they have settled
  task automatic st(input logic [2:0] e);
    bus(1'b0, 6'h00, 32'h0);
    chk({unst, lop, ais}, e);
    chk(rd, {29'h0, e});
  endtask : st
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    st(3'b000);
    bus(1'b0, 6'h04, 32'h0);
    chk(rd, 32'hf);
    bus(1'b1, 6'h00, 32'hff);
    bus(1'b0, 6'h14, 32'h0);
    chk(rd, 32'h0);
    st(3'b000);
  endtask : t_reset
  task automatic t_lop;
    src.send(7, 8'h00, 1'b0, 1'b0, 1'b0);
    st(3'b000);
    src.send(1, 8'h00, 1'b0, 1'b0, 1'b0);
    st(3'b010);
    src.send(2, 8'h00, 1'b1, 1'b0, 1'b0);
    st(3'b010);
    src.send(1, 8'h00, 1'b1, 1'b0, 1'b0);
    st(3'b000);
    src.send(7, 8'h00, 1'b1, 1'b1, 1'b0);
    st(3'b000);
    src.send(1, 8'h00, 1'b1, 1'b1, 1'b0);
    st(3'b010);
    src.send(3, 8'h00, 1'b1, 1'b0, 1'b0);
  endtask : t_lop
  task automatic t_ais;
    src.send(2, 8'hff, 1'b0, 1'b0, 1'b0);
    st(3'b000);
    src.send(9, 8'hff, 1'b0, 1'b0, 1'b0);
    st(3'b001);
    src.send(2, 8'h00, 1'b1, 1'b1, 1'b0);
    st(3'b001);
    src.send(1, 8'h00, 1'b1, 1'b1, 1'b0);
    st(3'b000);
  endtask : t_ais
  task automatic t_rdi;
    bus(1'b1, 6'h04, 32'h3);
    src.send(1, 8'h00, 1'b1, 1'b0, 1'b1);
    src.send(1, 8'h00, 1'b1, 1'b0, 1'b0);
    st(3'b000);
    src.send(1, 8'h00, 1'b1, 1'b0, 1'b1);
    st(3'b100);
    src.send(4, 8'h00, 1'b1, 1'b0, 1'b1);
    st(3'b000);
  endtask : t_rdi
  // frames offered while frozen must leave every defect untouched
  task automatic t_freeze;
    @(posedge clk);
    en <= 1'b0;
    src.send(8, 8'h00, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    en <= 1'b1;
    st(3'b000);
  endtask : t_freeze
  task automatic t_irq;
    bus(1'b0, 6'h08, 32'h0);
    chk(rd, 32'h7);
    bus(1'b1, 6'h0c, 32'h7);
    chk(irq, 1'b1);
    bus(1'b1, 6'h0c, 32'h0);
    chk(irq, 1'b0);
    bus(1'b1, 6'h08, 32'h7);
    bus(1'b0, 6'h08, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 6'h0c, 32'h7);
    chk(irq, 1'b0);
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lop();
    t_ais();
    t_rdi();
    t_freeze();
    t_irq();
    results();
  end
  // the sequence needs about 200 cycles; fifty times that means a hang
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : rx_path_pointer_defect_monitor_tb
`default_nettype wire
